/* design/lane_error_sync_monitor.v */
// Per-lane error counters, threshold flags, sync status and sync request logic.
//
// Behaviour
// - Eight-bit lane align enable register, bit x enables lane x, resets to 0xF.
// - Disparity status reads one flag per lane, set when count reaches threshold.
// - Table-miss status reads one flag per lane, set when count reaches threshold.
// - Unexpected control status reads one flag per lane, set at threshold.
// - Disparity command bit 7 clears the flag of the lane in bits 2..0 while its count is below threshold.
// - Disparity command bit 6 disables counting for the addressed lane.
// - Disparity command bit 5 zeroes the addressed lane's disparity counter.
// - Table-miss command: bit 7 clear flag, 6 disable, 5 zero counter, lane.
// - Unexpected command: bit 7 clear, 6 disable, 5 zero; bits 4..3 reserved.
// - Symbol lock reads per lane; writing bit 7 clears vector bit 0.
// - Any lane without symbol lock asserts the sync request output.
// - Frame align reads live per lane; writing bit 7 clears its interrupt.
// - Loss of frame alignment starts a new sync sequence automatically.
// - Checksum flag reads per lane; writing bit 7 clears vector bit 2.
// - Initial lane align reads per lane; writing bit 7 clears vector bit 3.
// - Loss of initial lane alignment also asserts the sync request output.
// - Vector bits 7, 6, 5 set when any lane's matching flag is set.
// - Readback returns selected lane's counter: 00 disp, 01 miss, 10 ctrl.
`timescale 1ns/1ps
`include "lane_error_sync_monitor_consts.vh"

module lane_error_sync_monitor (
  input  wire        sys_clk_i,                  // 40 MHz register clock
  input  wire        nrst_i,                     // Asynchronous reset, active low
  input  wire [11:0] reg_addr_i,                 // Register address
  input  wire [7:0]  reg_wdata_i,                // Register write data
  input  wire        reg_wr_i,                   // Write strobe, one cycle
  input  wire        reg_rd_i,                   // Read strobe, one cycle
  output wire [7:0]  reg_rdata_o,                // Read data, valid after read
  input  wire [7:0]  error_threshold_i,          // Shared error threshold
  input  wire [2:0]  readback_lane_select_i,     // Counter readback lane
  input  wire [1:0]  readback_counter_select_i,  // Counter readback type
  output wire [7:0]  error_count_o,              // Selected error counter
  input  wire [3:0]  disparity_error_i,          // Bad disparity event per lane
  input  wire [3:0]  table_miss_error_i,         // Not-in-table event per lane
  input  wire [3:0]  unexpected_ctrl_error_i,    // Unexpected control event per lane
  input  wire [3:0]  symbol_lock_i,              // Code group lock per lane
  input  wire [3:0]  frame_align_i,              // Frame alignment per lane
  input  wire [3:0]  checksum_ok_i,              // Last checksum good per lane
  input  wire [3:0]  lane_init_align_i,          // Initial lane alignment per lane
  output wire [7:0]  lane_align_enable_o,        // Deskew enable per lane
  output wire [7:0]  irq_vector_o,               // Aggregate interrupt vector
  output wire        sync_request_out_n_o,       // Sync request, active low
  output wire [3:0]  resync_start_o              // Per-lane resync pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [7:0] cnt_ff [0:`NUM_COUNTERS-1];
  reg [`NUM_COUNTERS-1:0] dis_ff;
  reg [`NUM_COUNTERS-1:0] flag_ff;
  reg [7:0]  align_ff;
  reg [7:0]  rdata_ff;
  reg [7:0]  count_ff;
  reg [3:0]  sync_irq_ff;
  reg [3:0]  lock_prev_ff;
  reg [3:0]  frame_prev_ff;
  reg [3:0]  chk_prev_ff;
  reg [3:0]  init_prev_ff;
  reg        sync_n_ff;
  reg [3:0]  resync_ff;
  reg [7:0]  nxt_rdata;
  wire [`NUM_COUNTERS-1:0] events;
  wire [3:0] loss;
  integer t;
  integer l;
  integer k;

  assign events = {unexpected_ctrl_error_i, table_miss_error_i, disparity_error_i};

  // A falling status bit on any lane raises that group's sticky interrupt.
  assign loss[0] = |(lock_prev_ff & ~symbol_lock_i);
  assign loss[1] = |(frame_prev_ff & ~frame_align_i);
  assign loss[2] = |(chk_prev_ff & ~checksum_ok_i);
  assign loss[3] = |(init_prev_ff & ~lane_init_align_i);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function [11:0] type_addr;
    input integer ty;
    begin
      case (ty)
        0:       type_addr = `ADDR_DISPARITY_ERROR;
        1:       type_addr = `ADDR_TABLE_MISS;
        default: type_addr = `ADDR_UNEXPECTED_CTRL;
      endcase
    end
  endfunction

  // Lane field must match exactly, so lane numbers 4..7 address nothing.
  function cmd_hit;
    input integer ty;
    input integer ln;
    begin
      cmd_hit = reg_wr_i && (reg_addr_i == type_addr(ty)) &&
                (reg_wdata_i[`CMD_LANE_MSB:`CMD_LANE_LSB] == ln[2:0]);
    end
  endfunction

  function flag_wr;
    input [11:0] addr;
    begin
      flag_wr = reg_wr_i && (reg_addr_i == addr) && reg_wdata_i[`FLAG_IRQ_CLEAR_BIT];
    end
  endfunction

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Command addresses read back status flags, so written command bits never read back.
  always @* begin
    nxt_rdata = `RST_ZERO8;
    case (reg_addr_i)
      `ADDR_LANE_ALIGN_ENABLE: nxt_rdata = align_ff;
      `ADDR_DISPARITY_ERROR:   nxt_rdata = {4'h0, flag_ff[3:0]};
      `ADDR_TABLE_MISS:        nxt_rdata = {4'h0, flag_ff[7:4]};
      `ADDR_UNEXPECTED_CTRL:   nxt_rdata = {4'h0, flag_ff[11:8]};
      `ADDR_SYMBOL_LOCK:       nxt_rdata = {4'h0, symbol_lock_i};
      `ADDR_FRAME_ALIGN:       nxt_rdata = {4'h0, frame_align_i};
      `ADDR_CHECKSUM_OK:       nxt_rdata = {4'h0, checksum_ok_i};
      `ADDR_LANE_INIT_ALIGN:   nxt_rdata = {4'h0, lane_init_align_i};
      default:                 nxt_rdata = `RST_ZERO8;
    endcase
  end

  // ****************************************************************
  // Counters, flags and registers
  // ****************************************************************
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (k = 0; k < `NUM_COUNTERS; k = k + 1) begin
        cnt_ff[k] <= `RST_ZERO8;
      end
      dis_ff        <= {`NUM_COUNTERS{1'b0}};
      flag_ff       <= {`NUM_COUNTERS{1'b0}};
      align_ff      <= `RST_LANE_ALIGN_ENABLE;
      rdata_ff      <= `RST_ZERO8;
      count_ff      <= `RST_ZERO8;
      sync_irq_ff   <= 4'h0;
      lock_prev_ff  <= 4'h0;
      frame_prev_ff <= 4'h0;
      chk_prev_ff   <= 4'h0;
      init_prev_ff  <= 4'h0;
      sync_n_ff     <= 1'b0;
      resync_ff     <= 4'h0;
    end else begin
      if (reg_wr_i && (reg_addr_i == `ADDR_LANE_ALIGN_ENABLE)) begin
        align_ff <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
      for (t = 0; t < `NUM_ERR_TYPES; t = t + 1) begin
        for (l = 0; l < `NUM_LANES; l = l + 1) begin
          k = t * `NUM_LANES + l;
          // Disable bit follows each write to the lane, so bit 6 low re-enables.
          if (cmd_hit(t, l)) begin
            dis_ff[k] <= reg_wdata_i[`CMD_COUNTER_DISABLE_BIT];
          end
          if (cmd_hit(t, l) && reg_wdata_i[`CMD_COUNTER_CLEAR_BIT]) begin
            cnt_ff[k] <= `RST_ZERO8;
          end else if (events[k] && !dis_ff[k] && (cnt_ff[k] != `COUNT_MAX)) begin
            cnt_ff[k] <= cnt_ff[k] + 8'h01;
          end
          // Threshold set wins over a clear arriving in the same cycle.
          if (cnt_ff[k] >= error_threshold_i) begin
            flag_ff[k] <= 1'b1;
          end else if (cmd_hit(t, l) && reg_wdata_i[`CMD_IRQ_CLEAR_BIT]) begin
            flag_ff[k] <= 1'b0;
          end
        end
      end
      lock_prev_ff  <= symbol_lock_i;
      frame_prev_ff <= frame_align_i;
      chk_prev_ff   <= checksum_ok_i;
      init_prev_ff  <= lane_init_align_i;
      sync_irq_ff[0] <= loss[0] | (sync_irq_ff[0] & ~flag_wr(`ADDR_SYMBOL_LOCK));
      sync_irq_ff[1] <= loss[1] | (sync_irq_ff[1] & ~flag_wr(`ADDR_FRAME_ALIGN));
      sync_irq_ff[2] <= loss[2] | (sync_irq_ff[2] & ~flag_wr(`ADDR_CHECKSUM_OK));
      sync_irq_ff[3] <= loss[3] | (sync_irq_ff[3] & ~flag_wr(`ADDR_LANE_INIT_ALIGN));
      // Request stays low until every lane holds both lock and initial alignment.
      sync_n_ff <= (&symbol_lock_i) & (&lane_init_align_i);
      resync_ff <= frame_prev_ff & ~frame_align_i;
      if ((readback_lane_select_i < `LANE_SEL_LIMIT) &&
          (readback_counter_select_i != `SEL_UNUSED)) begin
        count_ff <= cnt_ff[{readback_counter_select_i, readback_lane_select_i[1:0]}];
      end else begin
        count_ff <= `RST_ZERO8;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o          = rdata_ff;
  assign error_count_o        = count_ff;
  assign lane_align_enable_o  = align_ff;
  assign sync_request_out_n_o = sync_n_ff;
  assign resync_start_o       = resync_ff;
  // Vector comes straight from flip-flops: bits 7..5 OR each flag group, bits 3..0 direct.
  assign irq_vector_o = {|flag_ff[3:0], |flag_ff[7:4], |flag_ff[11:8], 1'b0,
                         sync_irq_ff};

endmodule

/* inc/lane_error_sync_monitor_consts.vh */
// Constants for the lane error and sync monitor register block.
`ifndef LANE_ERROR_SYNC_MONITOR_CONSTS_VH
`define LANE_ERROR_SYNC_MONITOR_CONSTS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_LANE_ALIGN_ENABLE   12'h46C
`define ADDR_DISPARITY_ERROR     12'h46D
`define ADDR_TABLE_MISS          12'h46E
`define ADDR_UNEXPECTED_CTRL     12'h46F
`define ADDR_SYMBOL_LOCK         12'h470
`define ADDR_FRAME_ALIGN         12'h471
`define ADDR_CHECKSUM_OK         12'h472
`define ADDR_LANE_INIT_ALIGN     12'h473

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_LANE_ALIGN_ENABLE    8'h0F
`define RST_ZERO8                8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CMD_IRQ_CLEAR_BIT        7
`define CMD_COUNTER_DISABLE_BIT  6
`define CMD_COUNTER_CLEAR_BIT    5
`define CMD_LANE_MSB             2
`define CMD_LANE_LSB             0
`define FLAG_IRQ_CLEAR_BIT       7
`define VEC_DISPARITY_BIT        7
`define VEC_TABLE_MISS_BIT       6
`define VEC_UNEXPECTED_BIT       5

// ****************************************************************
// Sizes and codes
// ****************************************************************
`define NUM_LANES                4
`define NUM_ERR_TYPES            3
`define NUM_COUNTERS             12
`define COUNT_MAX                8'hFF
`define SEL_UNUSED               2'h3
`define LANE_SEL_LIMIT           3'h4

`endif

/* tb/lane_monitor_chk_asserts.sv */
// Port-level assertion checker for the lane error and sync monitor.
`timescale 1ns/1ps
`include "lane_error_sync_monitor_consts.vh"
module lane_monitor_chk (
  input wire        sys_clk_i,                 // clock
  input wire        nrst_i,                    // reset, active low
  input wire [11:0] reg_addr_i,                // address
  input wire [7:0]  reg_wdata_i,               // write data
  input wire        reg_wr_i,                  // write strobe
  input wire        reg_rd_i,                  // read strobe
  input wire [7:0]  reg_rdata_o,               // read data
  input wire [1:0]  readback_counter_select_i, // counter type
  input wire [7:0]  error_count_o,             // counter readback
  input wire [3:0]  symbol_lock_i,             // lock per lane
  input wire [3:0]  frame_align_i,             // frame per lane
  input wire [3:0]  lane_init_align_i,         // initial align per lane
  input wire [7:0]  lane_align_enable_o,       // deskew enables
  input wire [7:0]  irq_vector_o,              // vector
  input wire        sync_request_out_n_o,      // sync request
  input wire [3:0]  resync_start_o             // resync pulses
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_sync_lock: assert property (|(~symbol_lock_i) |=> !sync_request_out_n_o)
    else $error("sync request missing on lock loss");
  chk_sync_init: assert property (|(~lane_init_align_i) |=> !sync_request_out_n_o)
    else $error("sync request missing on init align loss");
  chk_sync_release: assert property ((&symbol_lock_i) && (&lane_init_align_i)
    |=> sync_request_out_n_o) else $error("sync request stuck");
  chk_resync_pulse: assert property ($past(nrst_i, 3) |-> resync_start_o ==
    ($past(frame_align_i, 2) & ~$past(frame_align_i))) else $error("resync pulse wrong");
  chk_lock_irq: assert property (|($past(symbol_lock_i) & ~symbol_lock_i)
    |-> ##[1:2] irq_vector_o[0]) else $error("lock loss not flagged");
  chk_cnt_unused: assert property (readback_counter_select_i == 2'h3
    |=> error_count_o == 8'h00) else $error("unused select not zero");
  chk_vec_reserved: assert property (irq_vector_o[4] == 1'b0)
    else $error("reserved vector bit set");
  chk_align_reset: assert property ($rose(nrst_i) |-> lane_align_enable_o == 8'h0F)
    else $error("deskew reset value wrong");
  chk_align_write: assert property (reg_wr_i && reg_addr_i == `ADDR_LANE_ALIGN_ENABLE
    |=> lane_align_enable_o == $past(reg_wdata_i)) else $error("deskew write lost");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
endmodule
bind lane_error_sync_monitor lane_monitor_chk u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .readback_counter_select_i(readback_counter_select_i), .error_count_o(error_count_o),
  .symbol_lock_i(symbol_lock_i), .frame_align_i(frame_align_i),
  .lane_init_align_i(lane_init_align_i), .lane_align_enable_o(lane_align_enable_o),
  .irq_vector_o(irq_vector_o), .sync_request_out_n_o(sync_request_out_n_o),
  .resync_start_o(resync_start_o));

/* tb/lane_tx_model.sv */
// Behavioural model of the transmitter feeding the four lanes.
`timescale 1ns/1ps
module lane_tx_model (
  input  wire       sys_clk_i,   // clock
  input  wire       nrst_i,      // reset, active low
  input  wire [3:0] lock_drop_i, // lanes told to lose lock
  input  wire [3:0] bad_ck_i,    // lanes sending a bad checksum
  input  wire [2:0] fire_i,      // error kind to send
  input  wire [1:0] fire_lane_i, // lane carrying the error
  output wire [3:0] dis_o,       // disparity events
  output wire [3:0] miss_o,      // table miss events
  output wire [3:0] ctrl_o,      // control events
  output wire [3:0] lock_o,      // symbol lock
  output wire [3:0] frame_o,     // frame align
  output wire [3:0] ck_o,        // checksum good
  output reg  [3:0] ila_ff       // initial align
);
  wire [3:0] hot = 4'h1 << fire_lane_i;
  assign dis_o = fire_i[0] ? hot : 4'h0;
  assign miss_o = fire_i[1] ? hot : 4'h0;
  assign ctrl_o = fire_i[2] ? hot : 4'h0;
  assign lock_o = ~lock_drop_i;
  assign frame_o = lock_o & ila_ff;
  assign ck_o = ila_ff & ~bad_ck_i;
  // Alignment restarts only after the lane regains lock, so it never outruns the request.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) ila_ff <= 4'h0;
    else ila_ff <= lock_o;
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the lane error and sync monitor.
`timescale 1ns/1ps
`include "lane_error_sync_monitor_consts.vh"
module testbench;
  reg clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [7:0] wdata = 8'h00, thr = 8'h03, rdv;
  reg [2:0] lsel = 3'h0, fire = 3'h0;
  reg [1:0] csel = 2'h0, flane = 2'h0;
  reg [3:0] drop = 4'h0, badck = 4'h0;
  wire [7:0] rdata, cnt, align, vec;
  wire [3:0] de, te, ue, lock, fa, ck, ila, rs;
  wire syn_n;
  integer err_total = 0, check_count = 0, t;
  always #12.5 clk = ~clk;
  lane_error_sync_monitor DUT (.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .error_threshold_i(thr), .readback_lane_select_i(lsel), .readback_counter_select_i(csel),
    .error_count_o(cnt), .disparity_error_i(de), .table_miss_error_i(te),
    .unexpected_ctrl_error_i(ue), .symbol_lock_i(lock), .frame_align_i(fa),
    .checksum_ok_i(ck), .lane_init_align_i(ila), .lane_align_enable_o(align),
    .irq_vector_o(vec), .sync_request_out_n_o(syn_n), .resync_start_o(rs));
  lane_tx_model u_tx (.sys_clk_i(clk), .nrst_i(nrst), .lock_drop_i(drop), .bad_ck_i(badck),
    .fire_i(fire), .fire_lane_i(flane), .dis_o(de), .miss_o(te), .ctrl_o(ue),
    .lock_o(lock), .frame_o(fa), .ck_o(ck), .ila_ff(ila));
  task chk(input [7:0] got, input [7:0] exp); begin
    check_count = check_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  end endtask
  task wr_reg(input [11:0] a, input [7:0] d); begin
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  end endtask
  task rd_reg(input [11:0] a); begin
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 rdv = rdata;
  end endtask
  // Each event is a single-cycle pulse, so back-to-back hits count once each.
  task hit(input [2:0] k, input [1:0] l, input integer n); begin
    repeat (n) begin @(posedge clk); fire <= k; flane <= l; @(posedge clk); fire <= 3'h0; end
    repeat (3) @(posedge clk);
  end endtask
  task report_and_stop; begin
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_align; begin
    rd_reg(`ADDR_LANE_ALIGN_ENABLE); chk(rdv, `RST_LANE_ALIGN_ENABLE);
    wr_reg(`ADDR_LANE_ALIGN_ENABLE, 8'hA5); rd_reg(`ADDR_LANE_ALIGN_ENABLE);
    chk(rdv, 8'hA5); chk(align, 8'hA5);
    $display("test deskew done");
  end endtask
  task t_errors; begin
    for (t = 0; t < 3; t = t + 1) begin
      hit(3'h1 << t, t + 1, 2); rd_reg(`ADDR_DISPARITY_ERROR + t); chk(rdv, 8'h00);
      hit(3'h1 << t, t + 1, 1); rd_reg(`ADDR_DISPARITY_ERROR + t); chk(rdv, 8'h1 << (t + 1));
      chk(vec & (8'h80 >> t), 8'h80 >> t);
      lsel <= t + 1; csel <= t; repeat (3) @(posedge clk); chk(cnt, 8'h03);
      wr_reg(`ADDR_DISPARITY_ERROR + t, 8'hFC); rd_reg(`ADDR_DISPARITY_ERROR + t);
      chk(rdv, 8'h1 << (t + 1)); chk(cnt, 8'h03);
      wr_reg(`ADDR_DISPARITY_ERROR + t, 8'h21 + t); wr_reg(`ADDR_DISPARITY_ERROR + t, 8'h81 + t);
      rd_reg(`ADDR_DISPARITY_ERROR + t); chk(rdv, 8'h00); chk(cnt, 8'h00);
      wr_reg(`ADDR_DISPARITY_ERROR + t, 8'h41 + t); hit(3'h1 << t, t + 1, 1); chk(cnt, 8'h00);
      wr_reg(`ADDR_DISPARITY_ERROR + t, 8'h01 + t); hit(3'h1 << t, t + 1, 1); chk(cnt, 8'h01);
    end
    csel <= 2'h3; repeat (3) @(posedge clk); chk(cnt, 8'h00);
    $display("test error counters done");
  end endtask
  task t_sync; begin
    chk({7'h0, syn_n}, 8'h01);
    for (t = 0; t < 4; t = t + 1) wr_reg(`ADDR_SYMBOL_LOCK + t, 8'h80);
    badck <= 4'h1; repeat (3) @(posedge clk);
    rd_reg(`ADDR_CHECKSUM_OK); chk(rdv, 8'h0E); chk(vec & 8'h0F, 8'h04);
    badck <= 4'h0; drop <= 4'h2; @(posedge clk); #1;
    chk({4'h0, rs}, 8'h02);
    repeat (2) @(posedge clk);
    chk({7'h0, syn_n}, 8'h00);
    rd_reg(`ADDR_SYMBOL_LOCK); chk(rdv, 8'h0D); rd_reg(`ADDR_FRAME_ALIGN); chk(rdv, 8'h0D);
    rd_reg(`ADDR_LANE_INIT_ALIGN); chk(rdv, 8'h0D); chk(vec & 8'h0F, 8'h0F);
    drop <= 4'h0; repeat (4) @(posedge clk); chk({7'h0, syn_n}, 8'h01);
    for (t = 0; t < 4; t = t + 1) wr_reg(`ADDR_SYMBOL_LOCK + t, 8'h80);
    repeat (2) @(posedge clk); chk(vec & 8'h0F, 8'h00);
    $display("test sync done");
  end endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_align; t_errors; t_sync;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total = err_total + 1;
    report_and_stop;
  end
endmodule
